// [src/uches_event_select.sv]
// Functional notes
// - fill mask 01H counts modified-state allocations
// - modified allocation only from forwarded read-invalidate-own
// - fill masks 02H/04H/08H count E, S, F
// - fill mask 0FH counts every allocation except a modified fill without forwarded own
// - victim masks 01H/02H/04H count M, E, S
// - victim masks 08H/10H count I, F
// - modified victim written back to its home
// - victim mask 1FH counts every eviction with a state code from M to F
// - request masks 01H/02H count io hub reads/writes
// - request masks 04H/08H count remote reads/writes
// - request masks 10H/20H count local reads/writes
// - full masks count cycles tracker completely occupied
// - busy masks count cycles tracker holds entries
//
// Register access over APB and the register addresses were chosen for this implementation.
module uches_event_select #(
  parameter int unsigned NUM_CNT = 2,
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // last-level-cache allocation report
  input wire logic fill_valid,
  input uches_pkg::uches_fill_state_e fill_state,
  input wire logic fill_fwd_own,
  // last-level-cache eviction report
  input wire logic victim_valid,
  input uches_pkg::uches_victim_state_e victim_state,
  input wire logic victim_home_remote,
  // home agent request report
  input wire logic req_valid,
  input uches_pkg::uches_req_src_e req_src,
  input wire logic req_write,
  // tracker levels: bit 0 io hub, 1 remote, 2 local
  input wire logic [2:0] tracker_full,
  input wire logic [2:0] tracker_busy,
  // writeback request toward the home caching agent
  output logic wb_valid,
  output logic wb_remote
);

  // condition vectors fed to every counter
  uches_pkg::uches_evt_s evt;
  // modified fill that did not come from a forwarded own request
  logic bad_fill;
  // selection registers, one per counter
  uches_pkg::uches_sel_s sel_reg [NUM_CNT];
  // counter values
  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  // per-counter load strobes
  logic [NUM_CNT-1:0] cnt_load;
  // sticky status word
  logic [31:0] status_reg;
  // decoded read data and error for the current setup
  logic [31:0] rdata_next;
  logic err_next;
  // write that completes at this edge
  logic wr_fire;

  // setup phase of an apb transfer
  logic apb_setup;
  assign apb_setup = psel && !penable;
  // access edge: the slave answers one cycle after setup
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;

  // a modified fill is only legitimate as a forwarded read-invalidate-own line
  assign bad_fill = fill_valid && (fill_state == uches_pkg::FILL_M) && !fill_fwd_own;

  // build condition bits from the reports, one-hot for fill, victim and request; tracker levels pass through
  always_comb
  begin
    evt = '0;
    if (fill_valid && !bad_fill)
    begin
      evt.fill = 4'h1 << fill_state;
    end
    if (victim_valid)
    begin
      evt.victim = 5'h01 << victim_state;
    end
    if (req_valid)
    begin
      evt.req = 6'h01 << {req_src, req_write};
    end
    evt.full = tracker_full;
    evt.busy = tracker_busy;
  end

  // modified victims leave a writeback toward their home, local or remote
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wb_valid <= 1'b0;
      wb_remote <= 1'b0;
    end
    else
    begin
      wb_valid <= victim_valid && (victim_state == uches_pkg::VIC_M);
      wb_remote <= victim_valid && (victim_state == uches_pkg::VIC_M) && victim_home_remote;
    end
  end

  // counters, one instance each; software writes preload them
  for (genvar gi = 0; gi < NUM_CNT; gi++)
  begin : g_cnt
    uches_counter #(
      .CNT_W(CNT_W)
    ) u_counter (
      .clk_sys(clk_sys),
      .reset(reset),
      .sel(sel_reg[gi]),
      .evt(evt),
      .load(cnt_load[gi]),
      .load_value(pwdata[CNT_W-1:0]),
      .count(cnt_val[gi])
    );
  end

  // write decode for counter loads
  always_comb
  begin
    cnt_load = '0;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (wr_fire && paddr == uches_pkg::OFS_CNT0 + 12'(i) * uches_pkg::OFS_STRIDE)
      begin
        cnt_load[i] = 1'b1;
      end
    end
  end

  // selection registers steer which conditions each counter sees
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        sel_reg[i] <= uches_pkg::SEL_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (wr_fire && paddr == uches_pkg::OFS_SEL0 + 12'(i) * uches_pkg::OFS_STRIDE)
        begin
          sel_reg[i] <= pwdata[$bits(uches_pkg::uches_sel_s)-1:0];
        end
      end
    end
  end

  // status: write one to clear, a new bad fill in the same cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      status_reg <= uches_pkg::STATUS_RST;
    end
    else if (bad_fill)
    begin
      status_reg[uches_pkg::STATUS_BAD_FILL_BIT] <= 1'b1;
    end
    else if (wr_fire && paddr == uches_pkg::OFS_STATUS && pwdata[uches_pkg::STATUS_BAD_FILL_BIT])
    begin
      status_reg[uches_pkg::STATUS_BAD_FILL_BIT] <= 1'b0;
    end
  end

  // read decode; unmapped or misaligned addresses answer with an error
  always_comb
  begin
    rdata_next = uches_pkg::RDATA_RST;
    err_next = 1'b1;
    if (paddr == uches_pkg::OFS_STATUS)
    begin
      rdata_next = status_reg;
      err_next = 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (paddr == uches_pkg::OFS_SEL0 + 12'(i) * uches_pkg::OFS_STRIDE)
        begin
          rdata_next = 32'(sel_reg[i]);
          err_next = 1'b0;
        end
        else if (paddr == uches_pkg::OFS_CNT0 + 12'(i) * uches_pkg::OFS_STRIDE)
        begin
          rdata_next = 32'(cnt_val[i]);
          err_next = 1'b0;
        end
      end
    end
  end

  // one wait-free access cycle: answer registered at the setup edge,
  // so a read returns the counter as it stood in the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= uches_pkg::RDATA_RST;
    end
    else
    begin
      pready <= apb_setup;
      if (apb_setup)
      begin
        pslverr <= err_next;
        prdata <= pwrite ? uches_pkg::RDATA_RST : rdata_next;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // a modified victim seen in one cycle
  sequence s_m_victim;
    victim_valid && victim_state == uches_pkg::VIC_M;
  endsequence

  // the matching writeback the next cycle, home side kept
  sequence s_wb_out(logic remote);
    wb_valid && wb_remote == remote;
  endsequence

  a_m_fill_origin: assert property (evt.fill[0] |-> fill_fwd_own && fill_state == uches_pkg::FILL_M)
    else $error("modified fill counted without forwarded own request");
  a_bad_fill_flag: assert property (bad_fill |=> status_reg[uches_pkg::STATUS_BAD_FILL_BIT])
    else $error("bad modified fill not flagged");
  a_wb_on_victim: assert property (s_m_victim |=> s_wb_out($past(victim_home_remote)))
    else $error("modified victim not written back");
  a_wb_only_m: assert property (!(victim_valid && victim_state == uches_pkg::VIC_M) |=> !wb_valid)
    else $error("writeback without modified victim");
  a_fill_state_map: assert property (fill_valid && fill_state != uches_pkg::FILL_M
    |-> $onehot(evt.fill) && evt.fill[fill_state])
    else $error("fill state bit wrong");
  // state codes above the forward state carry no victim bit
  a_victim_state_map: assert property (victim_valid && victim_state <= uches_pkg::VIC_F
    |-> $onehot(evt.victim) && evt.victim[victim_state])
    else $error("victim state bit wrong");
  a_victim_no_state: assert property (victim_valid && victim_state > uches_pkg::VIC_F
    |-> evt.victim == 5'h00)
    else $error("unknown victim state counted");
  a_req_io_hub: assert property (req_valid && req_src == uches_pkg::SRC_IO_HUB
    |-> evt.req[1:0] == (req_write ? 2'b10 : 2'b01) && evt.req[5:2] == 4'h0)
    else $error("io hub request bit wrong");
  a_req_remote: assert property (req_valid && req_src == uches_pkg::SRC_REMOTE
    |-> evt.req[3:2] == (req_write ? 2'b10 : 2'b01))
    else $error("remote request bit wrong");
  a_req_local: assert property (req_valid && req_src == uches_pkg::SRC_LOCAL
    |-> evt.req[5:4] == (req_write ? 2'b10 : 2'b01))
    else $error("local request bit wrong");
  a_tracker_levels: assert property (evt.full == tracker_full && evt.busy == tracker_busy)
    else $error("tracker level not passed through");
  a_apb_answer: assert property (apb_setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule

// [src/uches_pkg.sv]
package uches_pkg;

  // event group codes
  localparam logic [7:0] EVT_FILL = 8'h0a;
  localparam logic [7:0] EVT_VICTIM = 8'h0b;
  localparam logic [7:0] EVT_REQ = 8'h20;
  localparam logic [7:0] EVT_FULL = 8'h21;
  localparam logic [7:0] EVT_BUSY = 8'h22;

  // unit masks that the assertions pin down
  localparam logic [7:0] UMASK_FILL_M = 8'h01;
  localparam logic [7:0] UMASK_FILL_ANY = 8'h0f;
  localparam logic [7:0] UMASK_VICTIM_ANY = 8'h1f;

  // register byte offsets, counter i sits at base plus i times stride
  localparam logic [11:0] OFS_SEL0 = 12'h000;
  localparam logic [11:0] OFS_CNT0 = 12'h004;
  localparam logic [11:0] OFS_STRIDE = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h040;

  // status field position and reset values
  localparam int unsigned STATUS_BAD_FILL_BIT = 0;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // clock rate of the counting domain
  localparam int unsigned CLK_MHZ = 250;

  // fill coherence state, bit index into the fill unit mask
  typedef enum logic [1:0] {
    FILL_M = 2'h0,
    FILL_E = 2'h1,
    FILL_S = 2'h2,
    FILL_F = 2'h3
  } uches_fill_state_e;

  // victim coherence state, bit index into the victim unit mask
  typedef enum logic [2:0] {
    VIC_M = 3'h0,
    VIC_E = 3'h1,
    VIC_S = 3'h2,
    VIC_I = 3'h3,
    VIC_F = 3'h4
  } uches_victim_state_e;

  // home request source; mask bit is source times two plus write
  typedef enum logic [1:0] {
    SRC_IO_HUB = 2'h0,
    SRC_REMOTE = 2'h1,
    SRC_LOCAL = 2'h2
  } uches_req_src_e;

  // selection register layout, low bits of the word
  typedef struct packed {
    logic enable;
    logic [7:0] umask;
    logic [7:0] code;
  } uches_sel_s;

  localparam uches_sel_s SEL_RST = '0;

  // per-cycle condition vectors, one bit per unit-mask bit
  typedef struct packed {
    logic [4:0] victim;
    logic [3:0] fill;
    logic [5:0] req;
    logic [2:0] full;
    logic [2:0] busy;
  } uches_evt_s;

endpackage

// [src/uches_counter.sv]
module uches_counter #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input uches_pkg::uches_sel_s sel,
  input uches_pkg::uches_evt_s evt,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  output logic [CNT_W-1:0] count
);

  // condition selected by code and unit mask
  logic hit;

  // unit-mask bits above a group's width are ignored
  always_comb
  begin
    hit = 1'b0;
    case (sel.code)
      uches_pkg::EVT_FILL: hit = |(evt.fill & sel.umask[3:0]);
      uches_pkg::EVT_VICTIM: hit = |(evt.victim & sel.umask[4:0]);
      uches_pkg::EVT_REQ: hit = |(evt.req & sel.umask[5:0]);
      uches_pkg::EVT_FULL: hit = |(evt.full & sel.umask[2:0]);
      uches_pkg::EVT_BUSY: hit = |(evt.busy & sel.umask[2:0]);
      default: hit = 1'b0; // unknown codes never count
    endcase
  end

  // software write beats a same-cycle event, so a preset value is exact
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count <= CNT_W'(uches_pkg::CNT_RST);
    end
    else if (load)
    begin
      count <= load_value;
    end
    else if (sel.enable && hit)
    begin
      count <= count + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_step_one: assert property (sel.enable && hit && !load |=> count == $past(count) + 1'b1)
    else $error("counter did not step by one");
  a_hold_idle: assert property (!(sel.enable && hit) && !load |=> $stable(count))
    else $error("counter moved without a selected event");
  a_load_wins: assert property (load |=> count == $past(load_value))
    else $error("software load lost");
  a_fill_m_only: assert property (sel.code == uches_pkg::EVT_FILL && sel.umask == uches_pkg::UMASK_FILL_M
    |-> hit == evt.fill[0])
    else $error("modified fill selection wrong");
  a_fill_any: assert property (sel.code == uches_pkg::EVT_FILL && sel.umask == uches_pkg::UMASK_FILL_ANY
    |-> hit == (|evt.fill))
    else $error("any-state fill selection wrong");
  a_victim_any: assert property (sel.code == uches_pkg::EVT_VICTIM && sel.umask == uches_pkg::UMASK_VICTIM_ANY
    |-> hit == (|evt.victim))
    else $error("any-state victim selection wrong");

endmodule

// [test/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset and apb master signals
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // event reports, all driven from one random word
  logic fill_valid = 1'b0;
  uches_pkg::uches_fill_state_e fill_state = uches_pkg::FILL_M;
  logic fill_fwd_own = 1'b0;
  logic victim_valid = 1'b0;
  uches_pkg::uches_victim_state_e victim_state = uches_pkg::VIC_M;
  logic victim_home_remote = 1'b0;
  logic req_valid = 1'b0;
  uches_pkg::uches_req_src_e req_src = uches_pkg::SRC_IO_HUB;
  logic req_write = 1'b0;
  logic [2:0] tracker_full = 3'h0;
  logic [2:0] tracker_busy = 3'h0;
  logic wb_valid;
  logic wb_remote;
  // scoreboard state
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] mcnt [2];
  uches_pkg::uches_sel_s msel [2];
  logic mstat = 1'b0;
  // code and umask pairs, two per run; last ones are union and unknown code
  logic [15:0] cases [26] = '{16'h0a01, 16'h0a02, 16'h0a04, 16'h0a08, 16'h0a0f, 16'h0b01, 16'h0b02,
    16'h0b04, 16'h0b08, 16'h0b10, 16'h0b1f, 16'h2001, 16'h2002, 16'h2004, 16'h2008, 16'h2010,
    16'h2020, 16'h2101, 16'h2102, 16'h2104, 16'h2201, 16'h2202, 16'h2204, 16'h2015, 16'h2107, 16'h30ff};

  // 250 mhz
  always #2 clk_sys = ~clk_sys;

  uches_event_select i_uches_event_select (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fill_valid(fill_valid), .fill_state(fill_state),
    .fill_fwd_own(fill_fwd_own), .victim_valid(victim_valid), .victim_state(victim_state),
    .victim_home_remote(victim_home_remote), .req_valid(req_valid), .req_src(req_src),
    .req_write(req_write), .tracker_full(tracker_full), .tracker_busy(tracker_busy),
    .wb_valid(wb_valid), .wb_remote(wb_remote));

  // one comparison, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // model: does this selection count this cycle's condition vectors
  function automatic logic hits(input uches_pkg::uches_sel_s s, input logic [3:0] vf,
    input logic [4:0] vv, input logic [5:0] vr, input logic [2:0] vfu, input logic [2:0] vb);
    if (!s.enable)
      return 1'b0;
    case (s.code)
      uches_pkg::EVT_FILL: return |(vf & s.umask[3:0]);
      uches_pkg::EVT_VICTIM: return |(vv & s.umask[4:0]);
      uches_pkg::EVT_REQ: return |(vr & s.umask[5:0]);
      uches_pkg::EVT_FULL: return |(vfu & s.umask[2:0]);
      uches_pkg::EVT_BUSY: return |(vb & s.umask[2:0]);
      default: return 1'b0;
    endcase
  endfunction

  // configure both counters, drive random events, compare counts, status and writebacks
  task automatic run(input int j);
    logic [31:0] r, x, w;
    logic e, wbp, wrp, bad;
    logic [3:0] vf;
    logic [4:0] vv;
    logic [5:0] vr;
    wbp = 1'b0;
    wrp = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      msel[k] = '{enable: ($urandom % 5 != 0), umask: cases[2*j+k][7:0], code: cases[2*j+k][15:8]};
      w = $urandom;
      w[16:0] = msel[k];
      apb(1'b1, uches_pkg::OFS_SEL0 + 12'(k) * uches_pkg::OFS_STRIDE, w, r, e);
      apb(1'b0, uches_pkg::OFS_SEL0 + 12'(k) * uches_pkg::OFS_STRIDE, w, r, e);
      x = 32'h0000_0000;
      x[16:0] = msel[k];
      chk(r, x);
      chk({31'h0000_0000, e}, 32'h0000_0000);
      // preload near the top so some runs wrap
      mcnt[k] = $urandom | 32'hffff_ff00;
      apb(1'b1, uches_pkg::OFS_CNT0 + 12'(k) * uches_pkg::OFS_STRIDE, mcnt[k], r, e);
    end
    for (int i = 0; i <= 40; i++)
    begin
      @(posedge clk_sys);
      r = (i < 40) ? $urandom : 32'h0000_0000;
      fill_valid <= r[0];
      fill_state <= uches_pkg::uches_fill_state_e'(r[2:1]);
      fill_fwd_own <= r[3] | r[4];
      victim_valid <= r[5];
      victim_state <= uches_pkg::uches_victim_state_e'(r[8:6]);
      victim_home_remote <= r[9];
      req_valid <= r[10];
      req_src <= uches_pkg::uches_req_src_e'(r[12:11]);
      req_write <= r[13];
      tracker_full <= r[16:14];
      tracker_busy <= r[19:17] | r[16:14];
      // modified fill without forwarded ownership is not a legal allocation
      bad = r[0] && r[2:1] == 2'h0 && !(r[3] | r[4]);
      mstat = mstat | bad;
      vf = 4'h0;
      vv = 5'h00;
      vr = 6'h00;
      if (r[0] && !bad)
        vf[r[2:1]] = 1'b1;
      if (r[5] && r[8:6] < 3'h5)
        vv[r[8:6]] = 1'b1;
      if (r[10] && r[12:11] < 2'h3)
        vr[{r[12:11], r[13]}] = 1'b1;
      for (int k = 0; k < 2; k++)
        if (hits(msel[k], vf, vv, vr, r[16:14], r[19:17] | r[16:14]))
          mcnt[k] = mcnt[k] + 32'h0000_0001;
      // writeback reflects the previous cycle's victim
      @(negedge clk_sys);
      chk({30'h0000_0000, wb_valid, wb_remote}, {30'h0000_0000, wbp, wbp & wrp});
      wbp = r[5] && r[8:6] == 3'h0;
      wrp = r[9];
    end
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b0, uches_pkg::OFS_CNT0 + 12'(k) * uches_pkg::OFS_STRIDE, 32'h0000_0000, r, e);
      chk(r, mcnt[k]);
      chk({31'h0000_0000, e}, 32'h0000_0000);
    end
    apb(1'b0, uches_pkg::OFS_STATUS, 32'h0000_0000, r, e);
    chk(r, {31'h0000_0000, mstat});
    apb(1'b1, uches_pkg::OFS_STATUS, 32'h0000_0001, r, e);
    mstat = 1'b0;
  endtask

  // main sequence
  initial
  begin
    logic [31:0] r;
    logic e;
    void'($urandom(28742));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    // reset values, then unmapped and misaligned places refused
    foreach (cases[i])
    begin
      if (i < 5)
      begin
        apb(1'b0, (i == 4) ? uches_pkg::OFS_STATUS : 12'(i) * 12'h004, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0000);
      end
    end
    apb(1'b1, 12'h081, 32'hffff_ffff, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b0, 12'h0c0, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    for (int j = 0; j < 13; j++)
      run(j);
    summarize();
  end

  // watchdog well beyond the expected one thousand or so cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
endmodule
